// [include/uabw_pkg.sv]
// package: register map, field positions, reset values and baud constants for the uart control block
// Function
// - low speed: fH / (64 x (N+1))
// - high speed: fH / (16 x (N+1))
// - free-running 8-bit timer, divisor 0..255
// - address bit is bit 7 or ninth
// - address word raises interrupt when enabled
// - non-address word discarded, no interrupt
// - wake request on falling edge, clock off
// - no pin wake while uart clock runs
// - wake request becomes interrupt; software restarts clock
// - wake disabled: edges ignored while clock off
// - receive enable gates overrun/available into request
// - idle enable gates idle flag into request
// - empty enable gates empty flag into request
// - single-wire off: shared pin receive only
// - single-wire on: pin role by enables
// - single-wire, both enables: receive only
// - upper seven single-wire bits read zero
// - one data register: write transmit, read receive
// - word length select 8 or 9, ninth bit
// - global and receiver enable take pin
// - empty flag: data moved to shifter
package uabw_pkg;
    // register byte offsets
    localparam logic [7:0] CONTROL_ONE_OFS = 8'h00;
    localparam logic [7:0] CONTROL_TWO_OFS = 8'h04;
    localparam logic [7:0] SINGLE_WIRE_CONTROL_OFS = 8'h08;
    localparam logic [7:0] SERIAL_DATA_BUFFER_OFS = 8'h0C;
    localparam logic [7:0] BAUD_DIVISOR_OFS = 8'h10;
    localparam logic [7:0] STATUS_OFS = 8'h14;
    // control_one fields
    localparam int GEN_BIT = 7;
    localparam int WLS_BIT = 6;
    localparam int RX9_BIT = 1;
    // control_two fields
    localparam int TXON_BIT = 7;
    localparam int RXON_BIT = 6;
    localparam int SPD_BIT = 5;
    localparam int ADDR_BIT = 4;
    localparam int WAKE_BIT = 3;
    localparam int RXI_BIT = 2;
    localparam int IDLI_BIT = 1;
    localparam int EMPI_BIT = 0;
    // status fields
    localparam int ST_TXE_BIT = 0;
    localparam int ST_RXA_BIT = 1;
    localparam int ST_OVR_BIT = 2;
    localparam int ST_IDLE_BIT = 3;
    localparam int ST_WAKE_BIT = 4;
    // reset values
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] DIVISOR_RST = 8'h00;
    // baud prescale per speed mode
    localparam logic [5:0] PRE_LOW_LAST = 6'd63;
    localparam logic [5:0] PRE_HIGH_LAST = 6'd15;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// [rtl/uabw_ctrl.sv]
// uart control block: baud generator, address filter, pin wake-up, interrupt gating, pin routing, axi4-lite registers
`timescale 1ns/1ns
module uabw_ctrl
(
    input wire logic clk_i, // 25 MHz clock
    input wire logic rstn_i, // async reset, active low
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic rx_word_valid_i, // received word pulse from receiver core
    input wire logic [8:0] rx_word_i, // received word, bit 8 is ninth bit
    input wire logic tx_shift_load_i, // shifter took the buffered character
    input wire logic tx_idle_i, // transmitter idle level
    input wire logic tx_serial_i, // serial stream from transmitter core
    input wire logic uart_clk_off_i, // uart clock stopped
    input wire logic shared_pin_i, // shared receive pin level
    output logic baud_tick_o, // one-cycle bit clock tick
    output logic [8:0] tx_word_o, // character to transmit, ninth bit on top
    output logic tx_word_valid_o, // buffer holds a character
    output logic rx_serial_o, // receive input routed to receiver core
    output logic shared_pin_o, // shared pin output value
    output logic shared_pin_oe_o, // shared pin drive enable
    output logic tx_pin_o, // transmit pin output value
    output logic tx_pin_oe_o, // transmit pin drive enable
    output logic wake_req_o, // wake-up request level
    output logic irq_o // uart interrupt request
);
    ////////////////////////////////////////////////////////////////////////
    // register state
    logic [7:0] ctrl1_q;
    logic [7:0] ctrl2_q;
    logic sgl_q;
    logic [7:0] div_q;
    logic [7:0] rx_data_q;
    logic rx_ninth_bit_q;
    logic [8:0] tx_word_q;
    logic tx_full_q;
    logic rx_available_q;
    logic overrun_q;
    logic wake_flag_q;
    logic [5:0] pre_q;
    logic [7:0] cnt_q;
    logic baud_tick_q;
    logic pin_prev_q;
    logic irq_q;
    logic aw_hold_q;
    logic w_hold_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [7:0] rd_addr_q;

    logic uon;
    logic wr_go;
    logic wr_ok;
    logic rd_go;
    logic data_rd;
    logic data_wr;
    logic addr_bit;
    logic word_keep;
    logic wake_clr;
    logic [5:0] pre_last;
    logic pin_fall;

    assign uon = ctrl1_q[uabw_pkg::GEN_BIT];
    ////////////////////////////////////////////////////////////////////////
    // axi write channel: address and data taken in either order
    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready = !w_hold_q && !bvalid_q;
    assign wr_go = aw_hold_q && w_hold_q && !bvalid_q;
    assign wr_ok = awaddr_q <= uabw_pkg::STATUS_OFS && awaddr_q[1:0] == 2'b00;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= uabw_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok ? uabw_pkg::RESP_OKAY : uabw_pkg::RESP_SLVERR;
            end
            else if (bvalid_q && s_axi_bready)
            begin
                bvalid_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi read channel: one-cycle answer, unmapped gives slverr
    assign s_axi_arready = !rvalid_q;
    assign rd_go = s_axi_arvalid && !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign data_rd = rd_go && s_axi_araddr == uabw_pkg::SERIAL_DATA_BUFFER_OFS;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= uabw_pkg::RESP_OKAY;
            rd_addr_q <= 8'h00;
        end
        else if (rd_go)
        begin
            rvalid_q <= 1'b1;
            rd_addr_q <= s_axi_araddr;
            rresp_q <= uabw_pkg::RESP_OKAY;
            case (s_axi_araddr)
                uabw_pkg::CONTROL_ONE_OFS: rdata_q <= {24'h00_0000, ctrl1_q[7:2], rx_ninth_bit_q, 1'b0};
                uabw_pkg::CONTROL_TWO_OFS: rdata_q <= {24'h00_0000, ctrl2_q};
                uabw_pkg::SINGLE_WIRE_CONTROL_OFS: rdata_q <= {31'h0000_0000, sgl_q};
                uabw_pkg::SERIAL_DATA_BUFFER_OFS: rdata_q <= {24'h00_0000, rx_data_q};
                uabw_pkg::BAUD_DIVISOR_OFS: rdata_q <= {24'h00_0000, div_q};
                uabw_pkg::STATUS_OFS: rdata_q <= {27'h000_0000, wake_flag_q, tx_idle_i, overrun_q,
                                                  rx_available_q, !tx_full_q};
                default:
                begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= uabw_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_q && s_axi_rready)
        begin
            rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers; clearing the global enable drops both path enables
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ctrl1_q <= uabw_pkg::CONTROL_RST;
            ctrl2_q <= uabw_pkg::CONTROL_RST;
            sgl_q <= 1'b0;
            div_q <= uabw_pkg::DIVISOR_RST;
        end
        else
        begin
            if (wr_go && wstrb_q[0])
            begin
                case (awaddr_q)
                    uabw_pkg::CONTROL_ONE_OFS: ctrl1_q <= wdata_q[7:0];
                    uabw_pkg::CONTROL_TWO_OFS: ctrl2_q <= wdata_q[7:0];
                    uabw_pkg::SINGLE_WIRE_CONTROL_OFS: sgl_q <= wdata_q[0];
                    uabw_pkg::BAUD_DIVISOR_OFS: div_q <= wdata_q[7:0];
                    default: ;
                endcase
            end
            if (!uon)
            begin
                ctrl2_q[uabw_pkg::TXON_BIT] <= 1'b0;
                ctrl2_q[uabw_pkg::RXON_BIT] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // baud generator: prescale 64 or 16, then 8-bit divisor down-count
    assign pre_last = ctrl2_q[uabw_pkg::SPD_BIT] ? uabw_pkg::PRE_HIGH_LAST : uabw_pkg::PRE_LOW_LAST;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pre_q <= 6'd0;
            cnt_q <= 8'h00;
            baud_tick_q <= 1'b0;
        end
        else if (!uon)
        begin
            pre_q <= 6'd0;
            cnt_q <= div_q;
            baud_tick_q <= 1'b0;
        end
        else
        begin
            baud_tick_q <= 1'b0;
            if (pre_q >= pre_last)
            begin
                pre_q <= 6'd0;
                if (cnt_q == 8'h00)
                begin
                    cnt_q <= div_q;
                    baud_tick_q <= 1'b1;
                end
                else
                begin
                    cnt_q <= cnt_q - 8'h01;
                end
            end
            else
            begin
                pre_q <= pre_q + 6'd1;
            end
        end
    end
    assign baud_tick_o = baud_tick_q;

    ////////////////////////////////////////////////////////////////////////
    // receive side: address filter and data buffer
    assign addr_bit = ctrl1_q[uabw_pkg::WLS_BIT] ? rx_word_i[8] : rx_word_i[7];
    assign word_keep = rx_word_valid_i && uon && ctrl2_q[uabw_pkg::RXON_BIT]
                       && (!ctrl2_q[uabw_pkg::ADDR_BIT] || addr_bit);

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rx_data_q <= 8'h00;
            rx_ninth_bit_q <= 1'b0;
            rx_available_q <= 1'b0;
            overrun_q <= 1'b0;
        end
        else if (!uon || !ctrl2_q[uabw_pkg::RXON_BIT])
        begin
            rx_available_q <= 1'b0;
            overrun_q <= 1'b0;
        end
        else if (word_keep)
        begin
            if (rx_available_q && !data_rd)
            begin
                overrun_q <= 1'b1;
            end
            else
            begin
                rx_data_q <= rx_word_i[7:0];
                rx_ninth_bit_q <= rx_word_i[8];
                rx_available_q <= 1'b1;
            end
        end
        else if (data_rd)
        begin
            rx_available_q <= 1'b0;
            overrun_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit buffer: write fills, shifter load empties
    assign data_wr = wr_go && wstrb_q[0] && awaddr_q == uabw_pkg::SERIAL_DATA_BUFFER_OFS;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            tx_word_q <= 9'h000;
            tx_full_q <= 1'b0;
        end
        else if (!uon || !ctrl2_q[uabw_pkg::TXON_BIT])
        begin
            tx_full_q <= 1'b0;
        end
        else if (data_wr && !tx_full_q)
        begin
            tx_word_q <= {ctrl1_q[0], wdata_q[7:0]};
            tx_full_q <= 1'b1;
        end
        else if (tx_shift_load_i)
        begin
            tx_full_q <= 1'b0;
        end
    end
    assign tx_word_o = tx_word_q;
    assign tx_word_valid_o = tx_full_q;

    ////////////////////////////////////////////////////////////////////////
    // pin wake-up: only while uart clock is off and enabled
    assign pin_fall = pin_prev_q && !shared_pin_i;
    assign wake_clr = wr_go && wstrb_q[0] && awaddr_q == uabw_pkg::STATUS_OFS && wdata_q[uabw_pkg::ST_WAKE_BIT];

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pin_prev_q <= 1'b1;
            wake_flag_q <= 1'b0;
        end
        else
        begin
            pin_prev_q <= shared_pin_i;
            if (pin_fall && uart_clk_off_i && ctrl2_q[uabw_pkg::WAKE_BIT])
            begin
                wake_flag_q <= 1'b1;
            end
            else if (wake_clr)
            begin
                wake_flag_q <= 1'b0;
            end
        end
    end
    assign wake_req_o = wake_flag_q;

    ////////////////////////////////////////////////////////////////////////
    // interrupt request: enabled conditions ORed
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= (ctrl2_q[uabw_pkg::RXI_BIT] && (overrun_q || rx_available_q))
                     || (ctrl2_q[uabw_pkg::IDLI_BIT] && tx_idle_i)
                     || (ctrl2_q[uabw_pkg::EMPI_BIT] && !tx_full_q)
                     || wake_flag_q;
        end
    end
    assign irq_o = irq_q;

    ////////////////////////////////////////////////////////////////////////
    // pin routing for normal and single-wire modes
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rx_serial_o <= 1'b1;
            shared_pin_o <= 1'b1;
            shared_pin_oe_o <= 1'b0;
            tx_pin_o <= 1'b1;
            tx_pin_oe_o <= 1'b0;
        end
        else
        begin
            rx_serial_o <= (uon && ctrl2_q[uabw_pkg::RXON_BIT]) ? shared_pin_i : 1'b1;
            shared_pin_o <= tx_serial_i;
            shared_pin_oe_o <= sgl_q && uon && ctrl2_q[uabw_pkg::TXON_BIT]
                               && !ctrl2_q[uabw_pkg::RXON_BIT];
            tx_pin_o <= tx_serial_i;
            tx_pin_oe_o <= !sgl_q && uon && ctrl2_q[uabw_pkg::TXON_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    property p_tick_gap;
        baud_tick_o |=> !baud_tick_o [*8];
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("baud ticks too close");

    property p_low_period;
        baud_tick_o && !ctrl2_q[uabw_pkg::SPD_BIT] && cnt_q == 8'h00
        |-> ##64 (baud_tick_o || ctrl2_q[uabw_pkg::SPD_BIT]);
    endproperty
    a_low_period: assert property (p_low_period) else $error("low speed period not 64");

    property p_high_period;
        baud_tick_o && ctrl2_q[uabw_pkg::SPD_BIT] && cnt_q == 8'h00
        |-> ##16 (baud_tick_o || !ctrl2_q[uabw_pkg::SPD_BIT]);
    endproperty
    a_high_period: assert property (p_high_period) else $error("high speed period not 16");

    property p_addr_keep;
        rx_word_valid_i && uon && ctrl2_q[uabw_pkg::RXON_BIT] && ctrl2_q[uabw_pkg::ADDR_BIT] && addr_bit
        |=> rx_available_q || overrun_q;
    endproperty
    a_addr_keep: assert property (p_addr_keep) else $error("address word lost");

    property p_data_drop;
        rx_word_valid_i && ctrl2_q[uabw_pkg::ADDR_BIT] && !addr_bit && !data_rd && uon && ctrl2_q[uabw_pkg::RXON_BIT]
        |=> $stable(rx_available_q) && $stable(overrun_q);
    endproperty
    a_data_drop: assert property (p_data_drop) else $error("non-address word kept");

    property p_wake_set;
        pin_fall && uart_clk_off_i && ctrl2_q[uabw_pkg::WAKE_BIT] |=> ##1 wake_req_o && irq_o;
    endproperty
    a_wake_set: assert property (p_wake_set) else $error("wake request missing");

    property p_wake_cause;
        $rose(wake_req_o) |-> $past(uart_clk_off_i) && $past(ctrl2_q[uabw_pkg::WAKE_BIT]);
    endproperty
    a_wake_cause: assert property (p_wake_cause) else $error("wake without stopped clock");

    property p_irq_quiet;
        ctrl2_q[2:0] == 3'b000 && !wake_flag_q |=> !irq_o;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("request with enables off");

    property p_single_rx;
        sgl_q && uon && ctrl2_q[uabw_pkg::RXON_BIT] && ctrl2_q[uabw_pkg::TXON_BIT] |=> !shared_pin_oe_o;
    endproperty
    a_single_rx: assert property (p_single_rx) else $error("shared pin driven in receive");

    property p_swc_read;
        rvalid_q && rd_addr_q == uabw_pkg::SINGLE_WIRE_CONTROL_OFS |-> s_axi_rdata[31:1] == 31'h0000_0000;
    endproperty
    a_swc_read: assert property (p_swc_read) else $error("upper single-wire bits nonzero");

    c_tick: cover property (baud_tick_o ##[1:200] baud_tick_o);
    c_wake: cover property ($rose(wake_req_o));
    c_overrun: cover property ($rose(overrun_q));
    c_single_tx: cover property (shared_pin_oe_o);
endmodule

// [tb/uabw_node.sv]
// remote serial node on the shared line: low pulses of chosen length, else the pull-up
`timescale 1ns/1ns
module uabw_node
(
    input wire logic clk_i, // bench clock
    input wire logic start_i, // begin a low pulse
    input wire logic [3:0] hold_i, // low time in cycles less one, short or long
    input wire logic dut_oe_i, // device drives the shared line
    input wire logic dut_val_i, // device level on the shared line
    output logic line_o // resolved line level
);
    logic node_q = 1'b1;
    logic [3:0] left_q = 4'h0;
    ////////////////////////////////////////////////////////////////////////////////
    // pulse timer: the node lets go of the line once the low time has run out
    always_ff @(posedge clk_i)
    begin
        if (start_i)
            node_q <= 1'b0;
        else if (left_q == 4'h0)
            node_q <= 1'b1;
        left_q <= start_i ? hold_i : left_q - {3'b000, left_q != 4'h0};
    end
    // a driving device wins; a released line sits at its pull-up level
    assign line_o = dut_oe_i ? dut_val_i : node_q;
endmodule

// [tb/tb.sv]
// bench for the uart control block: axi4-lite register tasks and port checks
`timescale 1ns/1ns
module tb;
    logic clk_i = 1'b0, rstn_i = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rx_word_valid_i = 1'b0, tx_shift_load_i = 1'b0;
    logic tx_idle_i = 1'b0, tx_serial_i = 1'b1, uart_clk_off_i = 1'b0, node_start = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'h1, node_hold = 4'h0;
    logic [8:0] rx_word_i = 9'h000;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, shared_pin_i, baud_tick_o;
    logic tx_word_valid_o, rx_serial_o, shared_pin_o, shared_pin_oe_o, tx_pin_o, tx_pin_oe_o, wake_req_o, irq_o;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [8:0] tx_word_o;
    int n_errors = 0, total_checks = 0, cnt = 0, gap = 0;
    // scenario tables: reset reads, baud settings, pin ownership
    logic [7:0] ra [4] = '{8'h00, 8'h04, 8'h08, 8'h10};
    logic [7:0] bn [3] = '{8'h02, 8'h00, 8'h00};
    logic [7:0] pc [4] = '{8'hC0, 8'hC0, 8'h40, 8'h80};
    logic [3:0] ps = 4'b1110, pt = 4'b0001, ph = 4'b1000;
    logic [2:0] bsp = 3'b101;
    // one-bit outputs: 6 irq, 5 wake, 4 rx input, 3 loaded, 2 pin level, 1 pin oe, 0 tx oe
    wire [6:0] obs = {irq_o, wake_req_o, rx_serial_o, tx_word_valid_o, shared_pin_o, shared_pin_oe_o, tx_pin_oe_o};
    ////////////////////////////////////////////////////////////////////////////////
    // device and far-side node
    uabw_ctrl DUT (.clk_i, .rstn_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_word_valid_i, .rx_word_i,
        .tx_shift_load_i, .tx_idle_i, .tx_serial_i, .uart_clk_off_i, .shared_pin_i, .baud_tick_o, .tx_word_o,
        .tx_word_valid_o, .rx_serial_o, .shared_pin_o, .shared_pin_oe_o, .tx_pin_o, .tx_pin_oe_o, .wake_req_o, .irq_o);
    uabw_node node (.clk_i, .start_i(node_start), .hold_i(node_hold), .dut_oe_i(shared_pin_oe_o),
        .dut_val_i(shared_pin_o), .line_o(shared_pin_i));
    // 25 MHz clock
    always #20 clk_i = ~clk_i;
    // cycles between bit clock ticks
    always @(posedge clk_i) cnt <= baud_tick_o ? 1 : cnt + 1;
    always @(posedge clk_i) if (baud_tick_o) gap <= cnt;
    ////////////////////////////////////////////////////////////////////////////////
    // counted comparison, mismatch reported at once
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %s expected %h got %h", nm, e, g);
        end
    endtask
    // counts, verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // let n cycles pass, compare one output where it is settled
    task automatic pk(input int n, input string nm, input int k, input logic e);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
        chk(nm, e, obs[k]);
        @(posedge clk_i);
    endtask
    // axi4-lite write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ah, wh, bh;
        logic [1:0] br;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(negedge clk_i);
            ah = s_axi_awready;
            wh = s_axi_wready;
            bh = s_axi_bvalid;
            br = s_axi_bresp;
            @(posedge clk_i);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
        end
        while (!bh);
        chk("bresp", (a > 8'h14) ? uabw_pkg::RESP_SLVERR : uabw_pkg::RESP_OKAY, br);
    endtask
    // axi4-lite read, masked compare of the word
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic ah, rh;
        logic [31:0] d;
        logic [1:0] r;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(negedge clk_i);
            ah = s_axi_arready;
            rh = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk_i);
            if (ah) s_axi_arvalid <= 1'b0;
        end
        while (!rh);
        chk("rresp", (a > 8'h14) ? uabw_pkg::RESP_SLVERR : uabw_pkg::RESP_OKAY, r);
        chk($sformatf("reg %h", a), e, d & m);
    endtask
    // one received word from the receiver core
    task automatic rx(input logic [8:0] w);
        rx_word_i <= w;
        rx_word_valid_i <= 1'b1;
        @(posedge clk_i);
        rx_word_valid_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    // node pulls the shared line low for h+1 cycles
    task automatic fall(input logic [3:0] h);
        node_hold <= h;
        node_start <= 1'b1;
        @(posedge clk_i);
        node_start <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // watchdog: the tests need a few thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        $display("[ERR] watchdog expired");
        report_and_stop();
    end
    // reset, then the scenarios in turn
    initial
    begin
        repeat (16) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        foreach (ra[i])
            rd(ra[i], 32'hFFFF_FFFF, 32'h0000_0000);
        wr(8'h18, 8'h5A);
        rd(8'h18, 32'hFFFF_FFFF, 32'h0000_0000);
        wr(8'h08, 8'hFF);
        rd(8'h08, 32'hFFFF_FFFF, 32'h0000_0001);
        wr(8'h10, 8'hFF);
        rd(8'h10, 32'hFFFF_FFFF, 32'h0000_00FF);
        // bit clock period for both speeds and the smallest divisor
        foreach (bn[i])
        begin
            wr(8'h10, bn[i]);
            wr(8'h00, 8'h80);
            wr(8'h04, {2'b00, bsp[i], 5'h00});
            repeat (600) @(negedge clk_i);
            chk("baud period", (bsp[i] ? 16 : 64) * (bn[i] + 1), gap);
            @(posedge clk_i);
        end
        // pin ownership for single-wire and enable combinations
        tx_serial_i <= 1'b0;
        foreach (pc[i])
        begin
            wr(8'h08, {7'h00, ps[i]});
            wr(8'h04, pc[i]);
            pk(2, "tx pin oe", 0, pt[i]);
            pk(0, "shared pin oe", 1, ph[i]);
        end
        pk(0, "shared pin level", 2, 1'b0);
        chk("tx pin level", 0, tx_pin_o);
        tx_serial_i <= 1'b1;
        // transmit buffer: fill, refuse while full, emptied by the shifter
        wr(8'h08, 8'h00);
        wr(8'h00, 8'h81);
        wr(8'h04, 8'h81);
        wr(8'h0C, 8'hA5);
        wr(8'h0C, 8'h3C);
        pk(2, "irq full", 6, 1'b0);
        chk("tx word", 9'h1A5, tx_word_o);
        pk(0, "tx loaded", 3, 1'b1);
        rd(8'h14, 32'h0000_0001, 32'h0000_0000);
        tx_shift_load_i <= 1'b1;
        @(posedge clk_i);
        tx_shift_load_i <= 1'b0;
        pk(2, "irq empty", 6, 1'b1);
        wr(8'h04, 8'h82);
        tx_idle_i <= 1'b1;
        pk(2, "irq idle", 6, 1'b1);
        tx_idle_i <= 1'b0;
        pk(2, "irq busy", 6, 1'b0);
        // address filter on eight-bit words, overrun, read clears
        wr(8'h00, 8'h80);
        wr(8'h04, 8'h54);
        rx(9'h055);
        rd(8'h14, 32'h0000_0002, 32'h0000_0000);
        rx(9'h0A3);
        pk(0, "irq address", 6, 1'b1);
        rx(9'h0C4);
        rd(8'h14, 32'h0000_0006, 32'h0000_0006);
        rd(8'h0C, 32'h0000_00FF, 32'h0000_00A3);
        pk(1, "irq cleared", 6, 1'b0);
        // nine-bit words: the ninth bit marks an address
        wr(8'h00, 8'hC0);
        rx(9'h092);
        rd(8'h14, 32'h0000_0002, 32'h0000_0000);
        rx(9'h112);
        rd(8'h00, 32'h0000_0002, 32'h0000_0002);
        rd(8'h0C, 32'h0000_00FF, 32'h0000_0012);
        // receive interrupt masked; a node start bit reaches the receiver
        wr(8'h04, 8'h40);
        rx(9'h055);
        rd(8'h14, 32'h0000_0002, 32'h0000_0002);
        fall(4'h5);
        pk(4, "rx input", 4, 1'b0);
        pk(0, "irq masked", 6, 1'b0);
        // pin wake-up only while the uart clock is stopped and enabled
        wr(8'h04, 8'h08);
        fall(4'h3);
        pk(5, "wake clock on", 5, 1'b0);
        uart_clk_off_i <= 1'b1;
        fall(4'h3);
        pk(5, "wake", 5, 1'b1);
        pk(0, "irq wake", 6, 1'b1);
        uart_clk_off_i <= 1'b0;
        wr(8'h14, 8'h10);
        wr(8'h04, 8'h00);
        uart_clk_off_i <= 1'b1;
        fall(4'h3);
        pk(5, "wake disabled", 5, 1'b0);
        report_and_stop();
    end
endmodule
